// [sme_spi_master.sv]
// SPI master engine: register file, two-entry transmit buffer and serial shifter.
// Assumes one register port shared upstream by both access sides and PWM event pulses.
//
// Notes on behaviour
// R1: Last received word readable, 64 bits.
// R2: Transmit word taken from write-only register.
// R3: Data-write mode starts on top byte write.
// R4: Master writes whole datagram in one access.
// R5: Two-bit field picks one of four selects.
// R6: Bit 3 keeps select low after transfer.
// R7: Bits 4,5,6: LSB first, phase, polarity.
// R8: Start source decoded from bits 10:8.
// R9: Source 111 plus bit 15 starts once.
// R10: Status bit 0 ready; others zero.
// R11: Length field is bits minus one.
// R12: Clock is 25 MHz over (4+2N).
`timescale 1ns/1ps
`include "sme_defines.svh"

module sme_spi_master #(
	parameter int WORD_W = 64,
	parameter int DEPTH  = 2
) (
	input  wire logic               core_clk,
	input  wire logic               sys_rst,
	input  wire sme_pkg::sme_req_type regReq,
	output logic [63:0]             regRdata,
	output logic                    regRvalid,
	output logic                    txReady,
	input  wire logic               pwmPeriodStart,
	input  wire logic               pwmCentre,
	input  wire logic               pwmMarkA,
	input  wire logic               pwmMarkB,
	output logic                    spiSclk,
	output logic                    spiMosi,
	input  wire logic               spiMiso,
	output logic [3:0]              spiCsN
);
	import sme_pkg::*;

	// The shifter indexes 64-bit words with 6-bit positions and the buffer holds two entries.
	if (WORD_W != 64 || DEPTH != 2) begin : gBadParams
		$error("sme_spi_master supports only WORD_W 64 and DEPTH 2");
	end

	// Picks the word bit that belongs to serial position idx.
	function automatic logic [5:0] bitPos(input logic [5:0] idx, input logic [5:0] len,
		input logic lsb);
		bitPos = lsb ? idx : 6'(len - idx);
	endfunction

	logic [15:0]       conf_q;
	logic [5:0]        len_q;
	logic [7:0]        div_q;
	logic [63:0]       txWord_q;
	logic [63:0]       rxWord_q;
	logic [63:0]       fifo_q [DEPTH];
	logic              wrPtr_q, rdPtr_q;
	logic [1:0]        count_q;
	sme_state_type     state_q;
	logic [63:0]       shift_q, rxShift_q, rxNext, loadWord;
	logic [5:0]        curLen_q, bitIdx_q;
	logic [6:0]        edgeIdx_q;
	logic [10:0]       halfCnt_q, halfPer_q;
	logic              curLsb_q, curCpha_q, keep_q;
	logic [1:0]        curSel_q;
	sme_src_type       src;
	logic              wrHit, txPush, trig, start, tick, sampleEdge, shiftEdge, finish;
	logic              busy;

	assign src   = sme_src_type'(conf_q[`SME_CONF_SRC_HI:`SME_CONF_SRC_LO]);
	assign wrHit = regReq.write;
	assign busy  = (state_q == ST_SHIFT);
	// Word handed to the shifter at start: the buffer head in data-write mode.
	assign loadWord = (src == SRC_WRITE) ? fifo_q[rdPtr_q] : txWord_q; // R2

	// Transmit buffer: a write whose top byte completes the datagram queues the word.
	assign txReady = (count_q < 2'(DEPTH));
	assign txPush  = wrHit && regReq.addr == `SME_REG_TX && src == SRC_WRITE
		&& regReq.byteEn[len_q[5:3]] && txReady; // R3

	// Start source decode; a PWM event while busy is dropped rather than queued, a one-shot request waits until idle.
	always_comb begin
		case (src) // R8
			SRC_PERIOD:  trig = pwmPeriodStart;
			SRC_CENTRE:  trig = pwmCentre;
			SRC_MARK_A:  trig = pwmMarkA;
			SRC_MARK_B:  trig = pwmMarkB;
			SRC_MARK_AB: trig = pwmMarkA | pwmMarkB;
			SRC_ONESHOT: trig = conf_q[`SME_CONF_ONESHOT]; // R9
			default:     trig = 1'b0;
		endcase
	end
	assign start = !busy && ((src == SRC_WRITE) ? (count_q != 2'd0) : trig); // R3

	// Register writes; byte enables gate each lane of the wide transmit word.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			conf_q   <= `SME_CONF_RESET;
			len_q    <= `SME_LEN_RESET;
			div_q    <= `SME_DIV_RESET;
			txWord_q <= 64'h0;
		end else begin
			if (start && src == SRC_ONESHOT) begin
				conf_q[`SME_CONF_ONESHOT] <= 1'b0; // R9
			end
			if (wrHit && regReq.addr == `SME_REG_CONF) begin
				// A write lands after the self-clear so a fresh request is never lost.
				if (regReq.byteEn[0]) conf_q[7:0]  <= regReq.wdata[7:0];
				if (regReq.byteEn[1]) conf_q[15:8] <= regReq.wdata[15:8];
			end
			if (wrHit && regReq.addr == `SME_REG_LENGTH && regReq.byteEn[0]) begin
				len_q <= regReq.wdata[`SME_LEN_HI:0]; // R11
			end
			if (wrHit && regReq.addr == `SME_REG_DIVIDER && regReq.byteEn[0]) begin
				div_q <= regReq.wdata[7:0]; // R12
			end
			if (wrHit && regReq.addr == `SME_REG_TX) begin
				for (int b = 0; b < 8; b++) begin
					if (regReq.byteEn[b]) txWord_q[8*b +: 8] <= regReq.wdata[8*b +: 8]; // R2
				end
			end
		end
	end

	// Buffer pointers; the engine drains only when idle, so the buffer can really fill.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wrPtr_q <= 1'b0;
			rdPtr_q <= 1'b0;
			count_q <= 2'd0;
		end else begin
			if (txPush) wrPtr_q <= !wrPtr_q;
			if (start && src == SRC_WRITE) rdPtr_q <= !rdPtr_q;
			count_q <= 2'(count_q + {1'b0, txPush} - {1'b0, start && src == SRC_WRITE});
		end
	end

	// Buffer storage, filled with the merged transmit word.
	always_ff @(posedge core_clk) begin
		if (txPush) begin
			for (int b = 0; b < 8; b++) begin
				fifo_q[wrPtr_q][8*b +: 8] <= regReq.byteEn[b] ? regReq.wdata[8*b +: 8]
					: txWord_q[8*b +: 8];
			end
		end
	end

	// Register reads answer one cycle later; write-only and unmapped numbers read zero.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			regRdata  <= 64'h0;
			regRvalid <= 1'b0;
		end else begin
			regRvalid <= regReq.read;
			case (regReq.addr)
				`SME_REG_RX:     regRdata <= rxWord_q; // R1
				`SME_REG_CONF:   regRdata <= {48'h0, conf_q};
				`SME_REG_STATUS: regRdata <= {63'h0, !busy}; // R10
				default:         regRdata <= 64'h0;
			endcase
		end
	end

	// Half-period timing: each edge falls (2+N) reference ticks after the last.
	assign tick       = busy && (halfCnt_q == 11'(halfPer_q - 11'd1));
	assign sampleEdge = tick && (edgeIdx_q[0] == curCpha_q); // R7
	assign shiftEdge  = tick && (edgeIdx_q[0] != curCpha_q) && !(curCpha_q && edgeIdx_q == 7'd0);
	assign finish     = tick && (edgeIdx_q == {curLen_q, 1'b1}); // R11

	always_comb begin
		rxNext = rxShift_q;
		if (sampleEdge) rxNext[bitPos(bitIdx_q, curLen_q, curLsb_q)] = spiMiso;
	end

	// Transfer engine: settings are latched at start so a mid-transfer write cannot tear it.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_q   <= ST_IDLE;
			shift_q   <= 64'h0;
			rxShift_q <= 64'h0;
			curLen_q  <= 6'h0;
			bitIdx_q  <= 6'h0;
			edgeIdx_q <= 7'h0;
			halfCnt_q <= 11'h0;
			halfPer_q <= 11'h0;
			curLsb_q  <= 1'b0;
			curCpha_q <= 1'b0;
			spiSclk   <= 1'b0;
			spiMosi   <= 1'b0;
		end else if (start) begin
			state_q   <= ST_SHIFT;
			shift_q   <= loadWord; // R2
			rxShift_q <= 64'h0;
			curLen_q  <= len_q;
			bitIdx_q  <= 6'h0;
			edgeIdx_q <= 7'h0;
			halfCnt_q <= 11'h0;
			halfPer_q <= 11'((`SME_HALF_BASE + div_q) * `SME_REF_DIV); // R12
			curLsb_q  <= conf_q[`SME_CONF_LSB];
			curCpha_q <= conf_q[`SME_CONF_CPHA];
			spiSclk   <= conf_q[`SME_CONF_CPOL]; // R7
			spiMosi   <= loadWord[bitPos(6'h0, len_q, conf_q[`SME_CONF_LSB])];
		end else if (busy) begin
			halfCnt_q <= tick ? 11'h0 : 11'(halfCnt_q + 11'd1);
			rxShift_q <= rxNext;
			if (tick) begin
				spiSclk   <= !spiSclk;
				edgeIdx_q <= 7'(edgeIdx_q + 7'd1);
			end
			if (shiftEdge && bitIdx_q != curLen_q) begin
				bitIdx_q <= 6'(bitIdx_q + 6'd1);
				spiMosi  <= shift_q[bitPos(6'(bitIdx_q + 6'd1), curLen_q, curLsb_q)];
			end
			if (finish) state_q <= ST_IDLE;
		end else begin
			spiSclk <= conf_q[`SME_CONF_CPOL];
		end
	end

	// Received word updates only when a transfer completes.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rxWord_q <= 64'h0;
		end else if (finish) begin
			rxWord_q <= rxNext; // R1
		end
	end

	// Slave selects: released at the end unless chaining was asked for at start.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			spiCsN   <= 4'hF;
			curSel_q <= 2'd0;
			keep_q   <= 1'b0;
		end else if (start) begin
			curSel_q <= conf_q[`SME_CONF_SEL_HI:`SME_CONF_SEL_LO];
			keep_q   <= conf_q[`SME_CONF_KEEP];
			spiCsN   <= ~(4'h1 << conf_q[`SME_CONF_SEL_HI:`SME_CONF_SEL_LO]); // R5
		end else if (finish && !keep_q) begin
			spiCsN <= 4'hF; // R6
		end else if (!busy && !conf_q[`SME_CONF_KEEP]) begin
			spiCsN <= 4'hF; // R6
		end
	end

	// Helper counters watched only by the checks below.
	logic [7:0]  toggles_q;
	logic [10:0] stable_q;
	always_ff @(posedge core_clk) begin
		if (sys_rst || start) begin
			toggles_q <= 8'h0;
			stable_q  <= 11'h0;
		end else begin
			if (tick) toggles_q <= 8'(toggles_q + 8'd1);
			stable_q <= tick ? 11'h0 : 11'(stable_q + 11'd1);
		end
	end

	sequence topByteWrite;
		regReq.write && regReq.addr == `SME_REG_TX && src == SRC_WRITE
			&& regReq.byteEn[len_q[5:3]] && count_q == 2'd0 && !busy;
	endsequence

	autoStart_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R3
		topByteWrite |-> ##2 busy) else $error("data write did not start a transfer");
	oneShot_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R9
		src == SRC_ONESHOT && conf_q[15] && !busy |=> busy && !conf_q[15] || $past(wrHit))
		else $error("one-shot request did not launch once");
	reservedSrc_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R8
		src == SRC_RESERVED && !busy && count_q == 2'd0 |=> !busy)
		else $error("reserved source started a transfer");
	selectLine_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R5
		busy |-> spiCsN == ~(4'h1 << curSel_q)) else $error("wrong slave select");
	keepSelect_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R6
		$fell(busy) && keep_q |-> spiCsN != 4'hF) else $error("select released while chaining");
	releaseSelect_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R6
		$fell(busy) && !keep_q |-> spiCsN == 4'hF) else $error("select not released");
	edgeCount_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R11
		$fell(busy) |-> toggles_q == {1'b0, curLen_q, 1'b0} + 8'd2)
		else $error("wrong number of clock edges");
	halfPeriod_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R12
		$past(busy) && spiSclk != $past(spiSclk) |-> $past(stable_q) == 11'(halfPer_q - 11'd1))
		else $error("serial clock half period wrong");
	statusRead_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R10
		regReq.read && regReq.addr == `SME_REG_STATUS |=> regRvalid && regRdata[63:1] == 63'h0
			&& regRdata[0] == !$past(busy)) else $error("status read wrong");
	rxHold_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R1
		!finish |=> $stable(rxWord_q)) else $error("receive word changed outside completion");

endmodule // sme_spi_master

// [sme_defines.svh]
// Offsets, field positions, reset values and timing counts of the SPI master engine.
// Assumes the includer works at a core clock whose rate is given here in MHz.
`ifndef SME_DEFINES_SVH
`define SME_DEFINES_SVH

// Register numbers on the internal register port.
`define SME_REG_RX        8'h06
`define SME_REG_TX        8'h07
`define SME_REG_CONF      8'h08
`define SME_REG_STATUS    8'h09
`define SME_REG_LENGTH    8'h0A
`define SME_REG_DIVIDER   8'h0B

// Configuration field positions.
`define SME_CONF_SEL_LO   0
`define SME_CONF_SEL_HI   1
`define SME_CONF_KEEP     3
`define SME_CONF_LSB      4
`define SME_CONF_CPHA     5
`define SME_CONF_CPOL     6
`define SME_CONF_SRC_LO   8
`define SME_CONF_SRC_HI   10
`define SME_CONF_ONESHOT  15
`define SME_STATUS_READY  0
`define SME_LEN_HI        5

// Reset values.
`define SME_CONF_RESET    16'h0000
`define SME_LEN_RESET     6'h3F
`define SME_DIV_RESET     8'h00

// Serial clock timing: reference rate, core rate, and the fixed part of the half period.
`define SME_REF_MHZ       25
`define SME_CORE_MHZ      100
`define SME_REF_DIV       (`SME_CORE_MHZ / `SME_REF_MHZ)
`define SME_HALF_BASE     2

`endif

// [sme_pkg.sv]
// Types shared by the SPI master engine and its surroundings.
// Assumes sme_defines.svh is available on the include path.
package sme_pkg;

	// One request on the register port, merged from the network and host sides upstream.
	typedef struct packed {
		logic        write;
		logic        read;
		logic [7:0]  addr;
		logic [7:0]  byteEn;
		logic [63:0] wdata;
	} sme_req_type;

	// Start sources of the configuration field.
	typedef enum logic [2:0] {
		SRC_WRITE, SRC_PERIOD, SRC_CENTRE, SRC_MARK_A,
		SRC_MARK_B, SRC_MARK_AB, SRC_RESERVED, SRC_ONESHOT
	} sme_src_type;

	// Transfer engine states.
	typedef enum logic {ST_IDLE, ST_SHIFT} sme_state_type;

endpackage

// [sme_spi_slave_model.sv]
// Behavioural SPI slave that answers with a fixed word and records what it hears.
// Assumes the master moves the serial clock only while the select input is low.
`timescale 1ns/1ps

module sme_spi_slave_model #(
	parameter logic [63:0] PATTERN = 64'h0
) (
	input  wire logic        sclk,
	input  wire logic        mosi,
	input  wire logic        csN,
	input  wire logic        cpol,
	input  wire logic        cpha,
	output logic             miso,
	output logic [63:0]      rxWord
);
	logic [63:0] sh;
	int          got;
	logic        csSeen, sclkSeen;
	time         riseT;

	// One process owns both outputs and never blocks, so a clock edge that meets the
	// select release in the same time step still counts as the last sample.
	initial begin
		miso     = 1'b0;
		rxWord   = 64'h0;
		sh       = PATTERN;
		got      = 0;
		csSeen   = 1'b1;
		sclkSeen = 1'b0;
		riseT    = 0;
		forever begin
			@(csN or sclk);
			// Sample on the edge the mode names and move on at the other, never before a sample.
			if (sclk !== sclkSeen && (csSeen === 1'b0 || riseT == $time)) begin
				if ((sclk !== cpol) ^ cpha) begin
					rxWord = {rxWord[62:0], mosi};
					got++;
				end else if (got > 0) begin
					sh = sh << 1;
					miso <= #1 sh[63];
				end
			end
			sclkSeen = sclk;
			// Load the answer at select; a released line flips so stale data never looks valid.
			if (csN !== csSeen) begin
				csSeen = csN;
				if (csN === 1'b0) begin
					sh     = PATTERN;
					got    = 0;
					rxWord = 64'h0;
					miso <= #1 PATTERN[63];
				end else begin
					riseT = $time;
					miso <= #1 ~miso;
				end
			end
		end
	end
endmodule // sme_spi_slave_model

// [sme_spi_master_tb.sv]
// Self-checking bench for the SPI master engine with one slave model on its link.
// Assumes the engine, its package and its defines are compiled before this file.
`timescale 1ns/1ps
`include "sme_defines.svh"

module sme_spi_master_tb;
	import sme_pkg::*;
	localparam logic [63:0] SLV  = 64'hC3A5_0F1E_96D2_4B78;
	localparam logic [63:0] ONES = 64'hFFFF_FFFF_FFFF_FFFF;
	logic        core_clk, sys_rst, txReady, regRvalid, spiSclk, spiMosi, spiMiso;
	logic        cpolB, cphaB;
	logic [3:0]  spiCsN, ev;
	logic [63:0] regRdata, slvRx;
	sme_req_type req;
	int          errors, checkCount, cyc;

	sme_spi_master sme_spi_master_inst (.core_clk(core_clk), .sys_rst(sys_rst), .regReq(req),
		.regRdata(regRdata), .regRvalid(regRvalid), .txReady(txReady),
		.pwmPeriodStart(ev[0]), .pwmCentre(ev[1]), .pwmMarkA(ev[2]), .pwmMarkB(ev[3]),
		.spiSclk(spiSclk), .spiMosi(spiMosi), .spiMiso(spiMiso), .spiCsN(spiCsN));
	sme_spi_slave_model #(.PATTERN(SLV)) sme_spi_slave_model_inst (.sclk(spiSclk),
		.mosi(spiMosi), .csN(&spiCsN), .cpol(cpolB), .cpha(cphaB), .miso(spiMiso),
		.rxWord(slvRx));

	// Free-running core clock.
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Cut a hung run short; the ceiling is a few times the expected run.
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 40000) begin
			errors++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks %0d, mismatches %0d", checkCount, errors);
		if (errors == 0 && checkCount > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		checkCount++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic regWr(input logic [7:0] a, input logic [7:0] be, input logic [63:0] d);
		req = '{1'b1, 1'b0, a, be, d};
		tick(1);
		req = '0;
		tick(1);
	endtask

	task automatic regRd(input logic [7:0] a, output logic [63:0] d);
		int i;
		req = '{1'b0, 1'b1, a, 8'h00, 64'h0};
		tick(1);
		req = '0;
		for (i = 0; i < 3 && regRvalid !== 1'b1; i++) tick(1);
		chk("read valid", 64'h1, {63'h0, regRvalid});
		d = regRdata;
		tick(1);
	endtask

	task automatic pulse(input logic [3:0] v);
		ev = v;
		tick(1);
		ev = 4'h0;
	endtask

	task automatic waitCs(input logic v);
		int i;
		for (i = 0; i < 3000 && (&spiCsN) !== v; i++) tick(1);
		chk("select level", {63'h0, v}, {63'h0, &spiCsN});
	endtask

	function automatic logic [63:0] rev(input logic [63:0] v, input int n);
		rev = '0;
		for (int k = 0; k < n; k++) rev[n-1-k] = v[k];
	endfunction

	// One data-write transfer, judged on both the register and the slave side.
	task automatic xfer(input logic [15:0] cf, input int n, input logic [63:0] d);
		logic [63:0] m, r;
		m = ONES >> (64 - n);
		{cpolB, cphaB} = cf[6:5];
		regWr(`SME_REG_CONF, 8'h03, {48'h0, cf});
		regWr(`SME_REG_LENGTH, 8'h01, 64'(n - 1));
		regWr(`SME_REG_TX, 8'hFF, d);
		waitCs(1'b0);
		chk("select", {60'h0, ~(4'h1 << cf[1:0])}, {60'h0, spiCsN});
		waitCs(1'b1);
		regRd(`SME_REG_RX, r);
		chk("rx word", cf[4] ? rev(SLV >> (64 - n), n) : SLV >> (64 - n), r & m);
		chk("sent word", cf[4] ? rev(d & m, n) : d & m, slvRx & m);
	endtask

	task automatic tReset();
		logic [63:0] r;
		chk("ready out", 64'h1, {63'h0, txReady});
		chk("idle select", 64'hF, {60'h0, spiCsN});
		regRd(`SME_REG_STATUS, r);
		chk("status", 64'h1, r);
		regRd(`SME_REG_TX, r);
		chk("write-only read", 64'h0, r);
		regRd(8'h0C, r);
		chk("unmapped read", 64'h0, r);
		regWr(`SME_REG_CONF, 8'h03, 64'h7CB4);
		regRd(`SME_REG_CONF, r);
		chk("conf readback", 64'h7CB4, r);
		regWr(`SME_REG_CONF, 8'h03, 64'h0);
		$display("register test done");
	endtask

	// Reset length gives 64 bits; divider 1 gives twelve core cycles per half period.
	task automatic tTiming();
		int t, h, i;
		logic s;
		regWr(`SME_REG_DIVIDER, 8'h01, 64'h1);
		regWr(`SME_REG_TX, 8'hFF, 64'h0);
		waitCs(1'b0);
		s = spiSclk;
		t = 0;
		h = 0;
		for (i = 0; i < 5000 && (&spiCsN) !== 1'b1; i++) begin
			tick(1);
			h++;
			if (spiSclk !== s) begin
				t++;
				s = spiSclk;
				if (t == 2) chk("half period", 64'd12, 64'(h));
				h = 0;
			end
		end
		chk("clock edges", 64'd128, 64'(t));
		regWr(`SME_REG_DIVIDER, 8'h01, 64'h0);
		$display("timing test done");
	endtask

	task automatic tTrig();
		logic [3:0] hit[1:5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h8};
		logic [3:0] miss[1:5] = '{4'h2, 4'h4, 4'h8, 4'h1, 4'h1};
		for (int s = 1; s <= 7; s++) begin
			regWr(`SME_REG_CONF, 8'h03, 64'(s) << 8);
			pulse(s < 6 ? miss[s] : 4'hF);
			tick(8);
			chk("no start", 64'h1, {63'h0, &spiCsN});
			if (s == 7) regWr(`SME_REG_CONF, 8'h03, 64'h8700);
			else if (s < 6) pulse(hit[s]);
			if (s != 6) begin
				waitCs(1'b0);
				waitCs(1'b1);
			end
		end
		tick(40);
		chk("single launch", 64'h1, {63'h0, &spiCsN});
		$display("trigger test done");
	endtask

	task automatic tModes();
		int lens[4] = '{8, 64, 1, 13};
		for (int i = 0; i < 4; i++)
			xfer({9'h0, 2'(i), 1'(i == 1 || i == 2), 2'b00, 2'(i)}, lens[i], ONES ^ 64'(i));
		$display("mode test done");
	endtask

	task automatic tKeep();
		logic [63:0] r;
		regWr(`SME_REG_CONF, 8'h03, 64'h000A);
		regWr(`SME_REG_TX, 8'hFF, 64'h3C);
		waitCs(1'b0);
		regRd(`SME_REG_STATUS, r);
		chk("busy status", 64'h0, r);
		for (int i = 0; i < 300 && r !== 64'h1; i++) regRd(`SME_REG_STATUS, r);
		chk("kept select", 64'hB, {60'h0, spiCsN});
		regWr(`SME_REG_CONF, 8'h03, 64'h0002);
		tick(2);
		chk("released select", 64'hF, {60'h0, spiCsN});
		$display("keep test done");
	endtask

	// Fill the buffer until it refuses, then count the transfers that drain it.
	task automatic tBuffer();
		int i, n;
		logic c;
		for (i = 0; i < 3; i++) regWr(`SME_REG_TX, 8'hFF, 64'(i));
		chk("buffer full", 64'h0, {63'h0, txReady});
		regWr(`SME_REG_TX, 8'hFF, 64'h5);
		c = 1'b1;
		n = 0;
		for (i = 0; i < 3000; i++) begin
			tick(1);
			if (c && (&spiCsN) === 1'b0) n++;
			c = &spiCsN;
		end
		chk("transfers", 64'h3, 64'(n));
		chk("drained", 64'h1, {63'h0, txReady});
		$display("buffer test done");
	endtask

	// Main sequence: reset for eight cycles, then every scenario in turn.
	initial begin
		sys_rst = 1'b1;
		req = '0;
		ev = 4'h0;
		cpolB = 1'b0;
		cphaB = 1'b0;
		tick(8);
		sys_rst = 1'b0;
		tReset();
		tTiming();
		tTrig();
		tModes();
		tKeep();
		tBuffer();
		complete_run();
	end
endmodule // sme_spi_master_tb
